// file: design/csc_pkg.sv
// constants, types and layouts for the context synchronization control block
package csc_pkg;

   // machine state word, one bit per control
   typedef struct packed {
      logic spare;
      logic sleep_request;
      logic exc_little_endian;
      logic ext_irq_enable;
      logic user_mode_bit;
      logic float_avail_bit;
      logic machine_check_enable;
      logic float_exc_mode0;
      logic single_step_trace;
      logic branch_trace;
      logic float_exc_mode1;
      logic exception_prefix;
      logic instr_translate_on;
      logic data_translate_on;
      logic recoverable_exception;
      logic byte_order_select;
   } csc_msw_s;

   localparam logic [15:0] MSW_RST     = 16'h0000;

   // exception cause
   typedef enum logic [1:0] {
      CAUSE_NONE  = 2'h0,
      CAUSE_HIPRI = 2'h1,
      CAUSE_EXT   = 2'h2,
      CAUSE_CNT   = 2'h3
   } csc_cause_e;

   // barrier progress, gray along idle-wait-done
   typedef enum logic [1:0] {
      BAR_IDLE = 2'h0,
      BAR_WAIT = 2'h1,
      BAR_DONE = 2'h3
   } csc_bar_e;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_MASK   = 8'h08;
   localparam logic [7:0] OFS_DCNT   = 8'h0c;
   localparam logic [7:0] OFS_BRK    = 8'h10;
   localparam logic [7:0] OFS_MSW    = 8'h14;
   localparam logic [7:0] OFS_PTB    = 8'h18;

   // status and mask bit positions
   localparam int ST_EXC    = 0;
   localparam int ST_MISUSE = 1;
   localparam int ST_CNT    = 2;
   localparam int ST_MCHK   = 3;
   localparam int ST_W      = 4;

   // control bit position and reset values
   localparam int          CTRL_RUN = 0;
   localparam logic [31:0] DCNT_RST = 32'h0000_0000;
   localparam logic [31:0] PTB_RST  = 32'h0000_0000;
   localparam logic [31:0] BRK_RST  = 32'h0000_0000;

   // lag count after the counter sign change; the exception request follows the sign change by this count plus 2 cycles
   localparam int CNT_LAG_CYC = 2;

endpackage : csc_pkg

// file: design/csc_top.sv
// context synchronization control: msw commit, fetch context, exceptions, barrier, apb
module csc_top #(
   parameter int CNT_LAG = csc_pkg::CNT_LAG_CYC
) (
   input  wire logic              CLK_IN,
   input  wire logic              RESETN_IN,
   input  wire logic              CE_IN,
   input  wire logic              PSEL_IN,
   input  wire logic              PENABLE_IN,
   input  wire logic              PWRITE_IN,
   input  wire logic [7:0]        PADDR_IN,
   input  wire logic [31:0]       PWDATA_IN,
   output logic      [31:0]       PRDATA_OUT,
   output logic                   PREADY_OUT,
   output logic                   PSLVERR_OUT,
   input  wire logic              MSW_WR_IN,
   input  wire csc_pkg::csc_msw_s MSW_DATA_IN,
   input  wire logic              CSYNC_IN,
   input  wire logic              XLATE_WR_IN,
   input  wire logic              MBAR_IN,
   input  wire logic              RC_PEND_IN,
   input  wire logic              PTB_WR_IN,
   input  wire logic [31:0]       PTB_DATA_IN,
   output logic                   PTB_READY_OUT,
   input  wire logic              TLBI_IN,
   input  wire logic              TLBI_ACK_IN,
   output logic                   TLBI_BCAST_OUT,
   input  wire logic              EXT_IRQ_IN,
   input  wire logic              HIPRI_EXC_IN,
   input  wire logic              MCHK_IN,
   output logic                   EXC_TAKE_OUT,
   output csc_pkg::csc_cause_e    EXC_CAUSE_OUT,
   output logic                   MCHK_TAKE_OUT,
   output logic                   ISSUE_HOLD_OUT,
   output logic                   FLUSH_OUT,
   output csc_pkg::csc_msw_s      ARCH_MSW_OUT,
   output csc_pkg::csc_msw_s      FETCH_MSW_OUT,
   output logic                   ITLB_STALE_OUT,
   output logic                   MBAR_BUSY_OUT,
   output logic      [31:0]       PTB_OUT,
   output logic      [31:0]       BRK_ADDR_OUT,
   output logic                   IRQ_OUT
);

   // elaboration check on the lag counter
   if (CNT_LAG < 1 || CNT_LAG > 255) begin : g_chk
      $error("CNT_LAG must lie in 1..255");
   end

   // state
   csc_pkg::csc_msw_s             arch_ff, fetch_ff;
   csc_pkg::csc_cause_e           cause_ff;
   csc_pkg::csc_bar_e             bar_ff, nxt_bar;
   logic                          take_ff, flush_ff, mchk_ff, stale_ff, tlbi_pend_ff;
   logic                          bcast_ff, cnt_msb_ff, cnt_armed_ff, cnt_pend_ff;
   logic [7:0]                    lag_ff;
   logic [31:0]                   dcnt_ff, ptb_ff, brk_ff, prdata_ff;
   logic [csc_pkg::ST_W-1:0]      status_ff, mask_ff, rdclr_ff;
   logic                          run_ff;

   // apb decode
   wire setup    = CE_IN & PSEL_IN & ~PENABLE_IN;
   wire acc      = CE_IN & PSEL_IN & PENABLE_IN;
   wire hit_ctrl = PADDR_IN == csc_pkg::OFS_CTRL;
   wire hit_st   = PADDR_IN == csc_pkg::OFS_STATUS;
   wire hit_mask = PADDR_IN == csc_pkg::OFS_MASK;
   wire hit_dcnt = PADDR_IN == csc_pkg::OFS_DCNT;
   wire hit_brk  = PADDR_IN == csc_pkg::OFS_BRK;
   wire hit_msw  = PADDR_IN == csc_pkg::OFS_MSW;
   wire hit_ptb  = PADDR_IN == csc_pkg::OFS_PTB;
   wire hit_any  = hit_ctrl | hit_st | hit_mask | hit_dcnt | hit_brk | hit_msw | hit_ptb;
   wire wr_acc   = acc & PWRITE_IN & hit_any;
   wire rd_st    = acc & ~PWRITE_IN & hit_st;
   wire brk_wr   = wr_acc & hit_brk;
   wire dcnt_wr  = wr_acc & hit_dcnt;

   // read mux, sampled in the setup cycle
   wire [31:0] rd_val =
      hit_ctrl ? {31'h0, run_ff} :
      hit_st   ? {28'h0, status_ff} :
      hit_mask ? {28'h0, mask_ff} :
      hit_dcnt ? dcnt_ff :
      hit_brk  ? brk_ff :
      hit_msw  ? {16'h0, arch_ff} :
      hit_ptb  ? ptb_ff : 32'h0000_0000;

   // machine state written this cycle, else the committed one
   csc_pkg::csc_msw_s msw_cur, exc_entry, nxt_arch, nxt_fetch;
   assign msw_cur = MSW_WR_IN ? MSW_DATA_IN : arch_ff;

   // exception choice; enable taken from the write in flight
   wire en_eff   = msw_cur.ext_irq_enable;
   wire ext_req  = en_eff & EXT_IRQ_IN;
   wire cnt_req  = en_eff & cnt_pend_ff;
   wire take     = CE_IN & ~take_ff & (HIPRI_EXC_IN | ext_req | cnt_req);
   wire csc_pkg::csc_cause_e nxt_cause =
      HIPRI_EXC_IN ? csc_pkg::CAUSE_HIPRI :
      ext_req      ? csc_pkg::CAUSE_EXT :
      cnt_req      ? csc_pkg::CAUSE_CNT : csc_pkg::CAUSE_NONE;

   // exception entry state: enable off, byte order from exception bit
   always_comb begin
      exc_entry                   = msw_cur;
      exc_entry.ext_irq_enable    = 1'b0;
      exc_entry.byte_order_select = msw_cur.exc_little_endian;
   end

   // writes that change sleep or byte order synchronise on their own
   wire self_sync = MSW_WR_IN &
                    ((MSW_DATA_IN.sleep_request != arch_ff.sleep_request) |
                     (MSW_DATA_IN.byte_order_select != arch_ff.byte_order_select));
   wire sync_now  = CE_IN & (CSYNC_IN | take | self_sync);

   // fetch context moves only at a sync point
   assign nxt_arch  = take ? exc_entry : msw_cur;
   assign nxt_fetch = sync_now ? nxt_arch : fetch_ff;

   // barrier: wait for reference updates and remote invalidate acks
   wire bar_clear = ~RC_PEND_IN & ~tlbi_pend_ff;
   wire bar_fin   = CE_IN & (bar_ff == csc_pkg::BAR_WAIT) & bar_clear;
   wire ptb_ok    = (bar_ff == csc_pkg::BAR_DONE) & ~RC_PEND_IN;
   wire ptb_acc   = CE_IN & PTB_WR_IN & ptb_ok;
   wire misuse    = ptb_acc & (arch_ff.instr_translate_on | arch_ff.data_translate_on);

   always_comb begin
      nxt_bar = bar_ff;
      case (bar_ff)
         csc_pkg::BAR_IDLE: if (MBAR_IN) nxt_bar = csc_pkg::BAR_WAIT;
         csc_pkg::BAR_WAIT: if (bar_clear) nxt_bar = csc_pkg::BAR_DONE;
         csc_pkg::BAR_DONE: begin
            if (MBAR_IN) nxt_bar = csc_pkg::BAR_WAIT;
            else if (ptb_acc) nxt_bar = csc_pkg::BAR_IDLE;
         end
         default: nxt_bar = csc_pkg::BAR_IDLE;
      endcase
   end

   // down counter sign change and deliberate lag
   wire cnt_neg  = dcnt_ff[31] & ~cnt_msb_ff;
   wire lag_done = cnt_armed_ff & (lag_ff == 8'(CNT_LAG));
   wire cnt_took = take & (nxt_cause == csc_pkg::CAUSE_CNT);

   // status events; set wins over the read clear
   wire [csc_pkg::ST_W-1:0] ev = {MCHK_IN & fetch_ff.machine_check_enable, lag_done,
                                  misuse, take};

   // msw commit, exception pulse and flush
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         arch_ff  <= csc_pkg::csc_msw_s'(csc_pkg::MSW_RST);
         fetch_ff <= csc_pkg::csc_msw_s'(csc_pkg::MSW_RST);
         take_ff  <= 1'b0;
         cause_ff <= csc_pkg::CAUSE_NONE;
         flush_ff <= 1'b0;
         mchk_ff  <= 1'b0;
      end else if (CE_IN) begin
         arch_ff  <= nxt_arch;
         fetch_ff <= nxt_fetch;
         take_ff  <= take;
         cause_ff <= take ? nxt_cause : csc_pkg::CAUSE_NONE;
         flush_ff <= sync_now | brk_wr;
         mchk_ff  <= ev[csc_pkg::ST_MCHK];
      end
   end

   // barrier, page table base, invalidate tracking
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         bar_ff       <= csc_pkg::BAR_IDLE;
         ptb_ff       <= csc_pkg::PTB_RST;
         stale_ff     <= 1'b0;
         tlbi_pend_ff <= 1'b0;
         bcast_ff     <= 1'b0;
      end else if (CE_IN) begin
         bar_ff       <= nxt_bar;
         if (ptb_acc) ptb_ff <= PTB_DATA_IN;
         stale_ff     <= TLBI_IN | XLATE_WR_IN | (stale_ff & ~(sync_now | bar_fin));
         tlbi_pend_ff <= TLBI_IN | (tlbi_pend_ff & ~TLBI_ACK_IN);
         bcast_ff     <= TLBI_IN;
      end
   end

   // down counter
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         dcnt_ff      <= csc_pkg::DCNT_RST;
         cnt_msb_ff   <= 1'b0;
         cnt_armed_ff <= 1'b0;
         lag_ff       <= 8'h00;
         cnt_pend_ff  <= 1'b0;
      end else if (CE_IN) begin
         if (dcnt_wr) dcnt_ff <= PWDATA_IN;
         else if (run_ff) dcnt_ff <= dcnt_ff - 32'h0000_0001;
         cnt_msb_ff   <= dcnt_ff[31];
         cnt_armed_ff <= cnt_neg | (cnt_armed_ff & ~lag_done);
         lag_ff       <= cnt_armed_ff ? lag_ff + 8'h01 : 8'h00;
         cnt_pend_ff  <= lag_done | (cnt_pend_ff & ~cnt_took);
      end
   end

   // apb registers, read data and status with read clear
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         run_ff    <= 1'b0;
         mask_ff   <= '0;
         brk_ff    <= csc_pkg::BRK_RST;
         status_ff <= '0;
         rdclr_ff  <= '0;
         prdata_ff <= 32'h0000_0000;
      end else if (CE_IN) begin
         if (wr_acc & hit_ctrl) run_ff <= PWDATA_IN[csc_pkg::CTRL_RUN];
         if (wr_acc & hit_mask) mask_ff <= PWDATA_IN[csc_pkg::ST_W-1:0];
         if (brk_wr) brk_ff <= PWDATA_IN;
         if (setup) prdata_ff <= rd_val;
         if (setup) rdclr_ff <= hit_st ? status_ff : '0;
         status_ff <= (status_ff & ~(rd_st ? rdclr_ff : '0)) | ev;
      end
   end

   // outputs
   assign PRDATA_OUT     = prdata_ff;
   assign PREADY_OUT     = CE_IN;
   assign PSLVERR_OUT    = acc & ~hit_any;
   assign PTB_READY_OUT  = ptb_ok;
   assign TLBI_BCAST_OUT = bcast_ff;
   assign EXC_TAKE_OUT   = take_ff;
   assign EXC_CAUSE_OUT  = cause_ff;
   assign MCHK_TAKE_OUT  = mchk_ff;
   assign ISSUE_HOLD_OUT = take | take_ff;
   assign FLUSH_OUT      = flush_ff;
   assign ARCH_MSW_OUT   = arch_ff;
   assign FETCH_MSW_OUT  = fetch_ff;
   assign ITLB_STALE_OUT = stale_ff;
   assign MBAR_BUSY_OUT  = bar_ff == csc_pkg::BAR_WAIT;
   assign PTB_OUT        = ptb_ff;
   assign BRK_ADDR_OUT   = brk_ff;
   assign IRQ_OUT        = |(status_ff & mask_ff);

   // checks
   property p_en_off;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      (CE_IN && MSW_WR_IN && !MSW_DATA_IN.ext_irq_enable && !HIPRI_EXC_IN)
         |=> !EXC_TAKE_OUT;
   endproperty
   a_en_off: assert property (p_en_off) else $error("exception after enable cleared");

   property p_en_on;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      (CE_IN && MSW_WR_IN && MSW_DATA_IN.ext_irq_enable && EXT_IRQ_IN && !EXC_TAKE_OUT)
         |-> ISSUE_HOLD_OUT ##1 (EXC_TAKE_OUT && EXC_CAUSE_OUT != csc_pkg::CAUSE_NONE);
   endproperty
   a_en_on: assert property (p_en_on) else $error("pending exception not taken");

   property p_mchk;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      $rose(MCHK_TAKE_OUT) |-> $past(FETCH_MSW_OUT.machine_check_enable);
   endproperty
   a_mchk: assert property (p_mchk) else $error("machine check ignored enable");

   property p_ptb_hold;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      (MBAR_BUSY_OUT || RC_PEND_IN) |-> !PTB_READY_OUT;
   endproperty
   a_ptb_hold: assert property (p_ptb_hold) else $error("base write not held");

   property p_ptb_gate;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      (PTB_OUT != $past(PTB_OUT)) |-> $past(PTB_WR_IN && !RC_PEND_IN && !MBAR_BUSY_OUT);
   endproperty
   a_ptb_gate: assert property (p_ptb_gate) else $error("base changed without barrier");

   property p_stale;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      (CE_IN && TLBI_IN) |=> ITLB_STALE_OUT && TLBI_BCAST_OUT;
   endproperty
   a_stale: assert property (p_stale) else $error("invalidate not tracked");

   property p_cnt_lag;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      (CE_IN && cnt_neg) |=> !cnt_pend_ff || $past(cnt_pend_ff);
   endproperty
   a_cnt_lag: assert property (p_cnt_lag) else $error("counter exception too early");

   property p_sync;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      (CE_IN && CSYNC_IN) |=> FLUSH_OUT && (FETCH_MSW_OUT == ARCH_MSW_OUT);
   endproperty
   a_sync: assert property (p_sync) else $error("sync did not apply context");

   property p_exc_sync;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      $rose(EXC_TAKE_OUT) |-> FLUSH_OUT && !ARCH_MSW_OUT.ext_irq_enable;
   endproperty
   a_exc_sync: assert property (p_exc_sync) else $error("exception not synchronizing");

   property p_endian;
      @(posedge CLK_IN) disable iff (!RESETN_IN)
      (CE_IN && MSW_WR_IN && MSW_DATA_IN.byte_order_select != ARCH_MSW_OUT.byte_order_select)
         |=> FLUSH_OUT;
   endproperty
   a_endian: assert property (p_endian) else $error("byte order change not synced");

endmodule : csc_top

// file: verif/test_context_sync_control.sv
// self-checking bench for the context synchronization control block
module test_context_sync_control;
   timeunit 1ns;
   timeprecision 100ps;

   logic                CLK_IN, RESETN_IN, CE_IN, PSEL_IN, PENABLE_IN, PWRITE_IN;
   logic [7:0]          PADDR_IN;
   logic [31:0]         PWDATA_IN, PRDATA_OUT, PTB_DATA_IN, PTB_OUT, BRK_ADDR_OUT;
   logic                PREADY_OUT, PSLVERR_OUT, MSW_WR_IN, CSYNC_IN, XLATE_WR_IN, MBAR_IN;
   logic                RC_PEND_IN, PTB_WR_IN, PTB_READY_OUT, TLBI_IN, TLBI_ACK_IN;
   logic                TLBI_BCAST_OUT, EXT_IRQ_IN, HIPRI_EXC_IN, MCHK_IN, EXC_TAKE_OUT;
   logic                MCHK_TAKE_OUT, ISSUE_HOLD_OUT, FLUSH_OUT, ITLB_STALE_OUT;
   logic                MBAR_BUSY_OUT, IRQ_OUT, e, h, f;
   csc_pkg::csc_msw_s   MSW_DATA_IN, ARCH_MSW_OUT, FETCH_MSW_OUT, v;
   csc_pkg::csc_cause_e EXC_CAUSE_OUT;
   int                  err_total, n_compared, n;
   logic [31:0]         rnd, r, r0;

   // device under test, default counter lag
   csc_top i_dut (
      .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .CE_IN(CE_IN), .PSEL_IN(PSEL_IN),
      .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
      .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
      .PSLVERR_OUT(PSLVERR_OUT), .MSW_WR_IN(MSW_WR_IN), .MSW_DATA_IN(MSW_DATA_IN),
      .CSYNC_IN(CSYNC_IN), .XLATE_WR_IN(XLATE_WR_IN), .MBAR_IN(MBAR_IN),
      .RC_PEND_IN(RC_PEND_IN), .PTB_WR_IN(PTB_WR_IN), .PTB_DATA_IN(PTB_DATA_IN),
      .PTB_READY_OUT(PTB_READY_OUT), .TLBI_IN(TLBI_IN), .TLBI_ACK_IN(TLBI_ACK_IN),
      .TLBI_BCAST_OUT(TLBI_BCAST_OUT), .EXT_IRQ_IN(EXT_IRQ_IN),
      .HIPRI_EXC_IN(HIPRI_EXC_IN), .MCHK_IN(MCHK_IN), .EXC_TAKE_OUT(EXC_TAKE_OUT),
      .EXC_CAUSE_OUT(EXC_CAUSE_OUT), .MCHK_TAKE_OUT(MCHK_TAKE_OUT),
      .ISSUE_HOLD_OUT(ISSUE_HOLD_OUT), .FLUSH_OUT(FLUSH_OUT),
      .ARCH_MSW_OUT(ARCH_MSW_OUT), .FETCH_MSW_OUT(FETCH_MSW_OUT),
      .ITLB_STALE_OUT(ITLB_STALE_OUT), .MBAR_BUSY_OUT(MBAR_BUSY_OUT),
      .PTB_OUT(PTB_OUT), .BRK_ADDR_OUT(BRK_ADDR_OUT), .IRQ_OUT(IRQ_OUT)
   );

   // free-running 100 MHz clock
   initial begin
      CLK_IN = 1'b0;
      forever #5 CLK_IN = ~CLK_IN;
   end

   // next word of the bench lfsr
   function automatic logic [31:0] nxt_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt_rand

   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
      end
   endtask : chk

   // one edge, then let its updates settle
   task automatic tick();
      @(posedge CLK_IN);
      #1;
   endtask : tick

   // apb transfer: setup, access until pready sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge CLK_IN);
      PSEL_IN    <= 1'b1;
      PENABLE_IN <= 1'b0;
      PWRITE_IN  <= w;
      PADDR_IN   <= a;
      PWDATA_IN  <= d;
      @(posedge CLK_IN);
      PENABLE_IN <= 1'b1;
      do begin
         @(posedge CLK_IN);
      end while (PREADY_OUT !== 1'b1);
      rd = PRDATA_OUT;
      err = PSLVERR_OUT;
      PSEL_IN    <= 1'b0;
      PENABLE_IN <= 1'b0;
   endtask : apb

   // state word write pulse, issue hold seen in the decision cycle
   task automatic msw(input csc_pkg::csc_msw_s val, input logic irq, output logic hold);
      @(posedge CLK_IN);
      MSW_WR_IN   <= 1'b1;
      MSW_DATA_IN <= val;
      EXT_IRQ_IN  <= irq;
      #1 hold = ISSUE_HOLD_OUT;
      @(posedge CLK_IN);
      MSW_WR_IN <= 1'b0;
      #1;
   endtask : msw

   // counts, verdict, end of run
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done

   // hang guard, far beyond the expected hundred-odd cycles
   initial begin
      #50000;
      err_total++;
      test_done();
   end

   // main sequence
   initial begin
      {PSEL_IN, PENABLE_IN, PWRITE_IN, MSW_WR_IN, CSYNC_IN, XLATE_WR_IN, MBAR_IN} = '0;
      {RC_PEND_IN, PTB_WR_IN, TLBI_IN, TLBI_ACK_IN, EXT_IRQ_IN, HIPRI_EXC_IN, MCHK_IN} = '0;
      {PADDR_IN, PWDATA_IN, PTB_DATA_IN} = '0;
      MSW_DATA_IN = '0;
      v = '0;
      CE_IN = 1'b1;
      RESETN_IN = 1'b0;
      err_total = 0;
      n_compared = 0;
      rnd = 32'h0000_0019;
      repeat (4) @(posedge CLK_IN);
      RESETN_IN <= 1'b1;
      #1;
      chk({16'h0, ARCH_MSW_OUT}, {16'h0, csc_pkg::MSW_RST}, "arch msw reset");
      chk(PTB_OUT, csc_pkg::PTB_RST, "ptb reset");
      chk(32'(IRQ_OUT), 32'h0, "irq reset");
      // register access: random mask, unmapped and read-only places
      rnd = nxt_rand(rnd);
      apb(1'b1, csc_pkg::OFS_MASK, rnd, r, e);
      apb(1'b0, csc_pkg::OFS_MASK, '0, r, e);
      chk(r & 32'h0f, rnd & 32'h0f, "mask readback");
      apb(1'b1, csc_pkg::OFS_MASK, '0, r, e);
      apb(1'b0, 8'h1c, '0, r, e);
      chk(r, 32'h0, "unmapped read data");
      chk(32'(e), 32'h1, "unmapped read error");
      apb(1'b1, 8'hfc, rnd, r, e);
      chk(32'(e), 32'h1, "unmapped write");
      apb(1'b1, csc_pkg::OFS_MSW, rnd, r, e);
      chk({16'h0, ARCH_MSW_OUT}, 32'h0, "msw not writable");
      // enable cleared while an interrupt arrives
      v.ext_irq_enable = 1'b1;
      msw(v, 1'b0, h);
      chk(32'({h, EXC_TAKE_OUT}), 32'h0, "take without request");
      v.ext_irq_enable = 1'b0;
      msw(v, 1'b1, h);
      chk(32'({h, EXC_TAKE_OUT}), 32'h0, "take after disable");
      repeat (3) begin
         tick();
         chk(32'(EXC_TAKE_OUT), 32'h0, "take while disabled");
      end
      // enable set with the interrupt pending
      v.ext_irq_enable = 1'b1;
      msw(v, 1'b1, h);
      chk(32'(h), 32'h1, "issue hold");
      chk(32'({EXC_TAKE_OUT, EXC_CAUSE_OUT}), 32'h6, "ext take");
      chk(32'({FLUSH_OUT, ARCH_MSW_OUT.ext_irq_enable}), 32'h2, "exc flush");
      chk({16'h0, FETCH_MSW_OUT}, {16'h0, ARCH_MSW_OUT}, "exc context");
      @(posedge CLK_IN);
      EXT_IRQ_IN   <= 1'b0;
      HIPRI_EXC_IN <= 1'b1;
      @(posedge CLK_IN);
      HIPRI_EXC_IN <= 1'b0;
      #1 chk(32'({EXC_TAKE_OUT, EXC_CAUSE_OUT, FLUSH_OUT}), 32'hb, "hipri take");
      // translation and check enable wait for the sync
      v = '0;
      v.instr_translate_on = 1'b1;
      v.machine_check_enable = 1'b1;
      @(posedge CLK_IN);
      MCHK_IN     <= 1'b1;
      XLATE_WR_IN <= 1'b1;
      @(posedge CLK_IN);
      XLATE_WR_IN <= 1'b0;
      #1 chk(32'(ITLB_STALE_OUT), 32'h1, "xlate stale");
      msw(v, 1'b0, h);
      chk(32'({FETCH_MSW_OUT.instr_translate_on, FLUSH_OUT}), 32'h0, "early ctx");
      tick();
      chk(32'(MCHK_TAKE_OUT), 32'h0, "check before sync");
      @(posedge CLK_IN);
      CSYNC_IN <= 1'b1;
      @(posedge CLK_IN);
      CSYNC_IN <= 1'b0;
      #1 chk(32'(FLUSH_OUT), 32'h1, "sync flush");
      chk({16'h0, FETCH_MSW_OUT}, {16'h0, ARCH_MSW_OUT}, "sync context");
      tick();
      chk(32'(MCHK_TAKE_OUT), 32'h1, "check after sync");
      @(posedge CLK_IN);
      MCHK_IN <= 1'b0;
      // byte order and sleep writes synchronise by themselves
      for (int k = 0; k < 2; k++) begin
         v.byte_order_select ^= (k == 0);
         v.sleep_request ^= (k == 1);
         msw(v, 1'b0, h);
         chk(32'(FLUSH_OUT), 32'h1, "self sync flush");
         chk({16'h0, FETCH_MSW_OUT}, {16'h0, v}, "self sync ctx");
      end
      // breakpoint write flushes
      rnd = nxt_rand(rnd);
      apb(1'b1, csc_pkg::OFS_BRK, rnd, r, e);
      #1 f = FLUSH_OUT;
      tick();
      chk(32'(f | FLUSH_OUT), 32'h1, "brk flush");
      chk(BRK_ADDR_OUT, rnd, "brk value");
      // invalidate, then barrier holding the base write
      @(posedge CLK_IN);
      TLBI_IN <= 1'b1;
      @(posedge CLK_IN);
      TLBI_IN <= 1'b0;
      #1 chk(32'({TLBI_BCAST_OUT, ITLB_STALE_OUT}), 32'h3, "invalidate");
      rnd = nxt_rand(rnd);
      @(posedge CLK_IN);
      MBAR_IN     <= 1'b1;
      RC_PEND_IN  <= 1'b1;
      PTB_WR_IN   <= 1'b1;
      PTB_DATA_IN <= rnd;
      @(posedge CLK_IN);
      MBAR_IN <= 1'b0;
      repeat (3) begin
         tick();
         chk(32'({PTB_READY_OUT, MBAR_BUSY_OUT}), 32'h1, "rc pending");
      end
      @(posedge CLK_IN);
      RC_PEND_IN <= 1'b0;
      repeat (2) begin
         tick();
         chk(32'(PTB_READY_OUT), 32'h0, "ack pending");
      end
      @(posedge CLK_IN);
      TLBI_ACK_IN <= 1'b1;
      @(posedge CLK_IN);
      TLBI_ACK_IN <= 1'b0;
      n = 0;
      do begin
         @(posedge CLK_IN);
         n++;
      end while (PTB_READY_OUT !== 1'b1 && n < 20);
      chk(32'(PTB_READY_OUT), 32'h1, "barrier done");
      PTB_WR_IN <= 1'b0;
      #1 chk(PTB_OUT, rnd, "base value");
      repeat (2) tick();
      chk(32'(ITLB_STALE_OUT), 32'h0, "stale cleared");
      // base written with translation on: flagged, masked interrupt
      chk(32'(IRQ_OUT), 32'h0, "irq masked");
      apb(1'b1, csc_pkg::OFS_MASK, 32'h1 << csc_pkg::ST_MISUSE, r, e);
      #1 chk(32'(IRQ_OUT), 32'h1, "irq raised");
      apb(1'b0, csc_pkg::OFS_STATUS, '0, r, e);
      chk(r & 32'h3, 32'h3, "status events");
      #1 chk(32'(IRQ_OUT), 32'h0, "irq cleared by read");
      apb(1'b0, csc_pkg::OFS_STATUS, '0, r, e);
      chk(r & 32'h3, 32'h0, "status cleared");
      // down counter crosses zero with the enable set
      apb(1'b1, csc_pkg::OFS_MASK, 32'h1 << csc_pkg::ST_CNT, r, e);
      apb(1'b1, csc_pkg::OFS_DCNT, 32'h3, r, e);
      apb(1'b0, csc_pkg::OFS_DCNT, '0, r, e);
      chk(r, 32'h3, "counter readback");
      v.ext_irq_enable = 1'b1;
      msw(v, 1'b0, h);
      chk(32'({h, EXC_TAKE_OUT}), 32'h0, "no pending yet");
      apb(1'b1, csc_pkg::OFS_CTRL, 32'h1 << csc_pkg::CTRL_RUN, r, e);
      n = 0;
      do begin
         tick();
         n++;
      end while (EXC_TAKE_OUT !== 1'b1 && n < 40);
      chk(32'({EXC_TAKE_OUT, EXC_CAUSE_OUT}), 32'h7, "counter take");
      chk(32'(IRQ_OUT), 32'h1, "counter irq");
      // clock enable low freezes the counter and holds off the bus
      apb(1'b0, csc_pkg::OFS_DCNT, '0, r0, e);
      @(posedge CLK_IN);
      CE_IN <= 1'b0;
      repeat (4) @(posedge CLK_IN);
      chk(32'(PREADY_OUT), 32'h0, "ready while frozen");
      CE_IN <= 1'b1;
      apb(1'b0, csc_pkg::OFS_DCNT, '0, r, e);
      chk(r0 - r, 32'h4, "counter frozen");
      test_done();
   end

endmodule : test_context_sync_control
